/* File: common/cdtt_cfg.svh */
`ifndef CDTT_CFG_SVH
`define CDTT_CFG_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define CDTT_IDX_ADDR 4'h0
`define CDTT_IDX_ADDR_MASK 4'h1
`define CDTT_IDX_DATA 4'h2
`define CDTT_IDX_DATA_MASK 4'h3
`define CDTT_IDX_PC0 4'h4
`define CDTT_IDX_PC_MASK 4'h8
`define CDTT_IDX_CFG 4'h9
`define CDTT_IDX_STATUS 4'hA
`define CDTT_NUM_BP 9
`define CDTT_NUM_PC 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CDTT_BP_RESET 32'h0000_0000
`define CDTT_CFG_RESET 32'h0000_0000

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define CDTT_CFG_L1_LSB 0
`define CDTT_CFG_L1_MSB 2
`define CDTT_CFG_L2_LSB 3
`define CDTT_CFG_L2_MSB 5
`define CDTT_CFG_TWO_LEVEL 6
`define CDTT_CFG_ACT_IRQ 7
`define CDTT_CFG_THR_LSB 8
`define CDTT_CFG_THR_MSB 10
`define CDTT_CFG_ENABLE 11

// ----------------------------------------------------------------
// serial frame
// ----------------------------------------------------------------
`define CDTT_FRAME_BITS 6'd40
`define CDTT_FRAME_LAST 6'd39
`define CDTT_CMD_BITS 6'd8
`define CDTT_CMD_WRITE 39
`define CDTT_CMD_IDX_MSB 35
`define CDTT_CMD_IDX_LSB 32

// ----------------------------------------------------------------
// trace
// ----------------------------------------------------------------
`define CDTT_PST_HALTED 4'hF
`define CDTT_NIBBLES 3'h7
`define CDTT_FIFO_DEPTH 16
`define CDTT_WORD_BITS 32

`endif

/* File: common/cdtt_pkg.sv */
package cdtt_pkg;

    typedef enum logic [1:0]
    {
        CDTT_TRIG_IDLE = 2'b00,
        CDTT_TRIG_ARMED = 2'b01,
        CDTT_TRIG_FIRED = 2'b10
    } cdtt_trig_type;

    typedef enum logic [0:0]
    {
        CDTT_DRAIN_IDLE = 1'b0,
        CDTT_DRAIN_SHIFT = 1'b1
    } cdtt_drain_type;

endpackage

/* File: rtl/cdtt_fifo.sv */
`timescale 1ns/1ns
module cdtt_fifo
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
)
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign push = in_valid_in && !full;
    assign pop = out_ready_in && !empty;
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clock_in)
    begin
        if (push)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr <= '0;
        end
        else if (push)
        begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            rd_ptr <= '0;
        end
        else if (pop)
        begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

/* File: rtl/cdtt_top.sv */
`timescale 1ns/1ns
`include "cdtt_cfg.svh"
module cdtt_top
#(
    parameter bit FULL_TRACE = 1'b1
)
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic debug_serial_clock,
    input wire logic debug_serial_in,
    output logic debug_serial_out,
    input wire logic sup_mode_in,
    input wire logic sup_wr_in,
    input wire logic sup_rd_in,
    input wire logic [3:0] sup_index_in,
    input wire logic [31:0] sup_wdata_in,
    output logic [31:0] sup_rdata_out,
    input wire logic bus_valid_in,
    input wire logic [31:0] bus_addr_in,
    input wire logic [31:0] bus_data_in,
    input wire logic pc_valid_in,
    input wire logic [31:0] pc_in,
    input wire logic resume_in,
    input wire logic debug_irq_done_in,
    input wire logic [2:0] irq_level_in,
    output logic halt_request_out,
    output logic debug_irq_out,
    output logic irq_allow_out,
    input wire logic [3:0] core_status_in,
    input wire logic trace_valid_in,
    input wire logic [31:0] trace_data_in,
    output logic trace_ready_out,
    output logic [3:0] processor_status_bus_out,
    output logic [3:0] debug_data_bus_out,
    output logic trace_clock_out,
    output logic halted_indicator_out
);

    // ----------------------------------------------------------------
    // link domain: serial shifter
    // ----------------------------------------------------------------
    logic link_rst_meta;
    logic link_rst_n;
    logic [5:0] bit_cnt;
    logic [39:0] shift_in;
    logic [39:0] frame_word;
    logic frame_toggle;
    logic [31:0] shift_out;
    logic [31:0] rd_hold;

    always_ff @(posedge debug_serial_clock)
    begin
        link_rst_meta <= rst_n_in;
        link_rst_n <= link_rst_meta;
    end

    always_ff @(posedge debug_serial_clock)
    begin
        if (!link_rst_n)
        begin
            bit_cnt <= 6'h00;
        end
        else if (bit_cnt == `CDTT_FRAME_LAST)
        begin
            bit_cnt <= 6'h00;
        end
        else
        begin
            bit_cnt <= bit_cnt + 6'h01;
        end
    end

    always_ff @(posedge debug_serial_clock)
    begin
        if (!link_rst_n)
        begin
            shift_in <= 40'h00_0000_0000;
        end
        else
        begin
            shift_in <= {shift_in[38:0], debug_serial_in};
        end
    end

    // completed frame held stable for a whole frame while the core picks it up
    always_ff @(posedge debug_serial_clock)
    begin
        if (!link_rst_n)
        begin
            frame_word <= 40'h00_0000_0000;
            frame_toggle <= 1'b0;
        end
        else if (bit_cnt == `CDTT_FRAME_LAST)
        begin
            frame_word <= {shift_in[38:0], debug_serial_in};
            frame_toggle <= ~frame_toggle;
        end
    end

    // read data of the previous frame leaves during the data field
    always_ff @(posedge debug_serial_clock)
    begin
        if (!link_rst_n)
        begin
            shift_out <= 32'h0000_0000;
        end
        else if (bit_cnt == (`CDTT_CMD_BITS - 6'h01))
        begin
            shift_out <= rd_hold;
        end
        else
        begin
            shift_out <= {shift_out[30:0], 1'b0};
        end
    end

    always_ff @(posedge debug_serial_clock)
    begin
        if (!link_rst_n)
        begin
            debug_serial_out <= 1'b0;
        end
        else
        begin
            debug_serial_out <= shift_out[31];
        end
    end

    // ----------------------------------------------------------------
    // core domain: frame pickup
    // ----------------------------------------------------------------
    logic tog_meta;
    logic tog_sync;
    logic tog_prev;
    logic ser_req;
    logic ser_wr;
    logic [3:0] ser_idx;
    logic [31:0] ser_data;

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_prev <= 1'b0;
        end
        else
        begin
            tog_meta <= frame_toggle;
            tog_sync <= tog_meta;
            tog_prev <= tog_sync;
        end
    end

    assign ser_req = tog_sync ^ tog_prev;
    assign ser_wr = ser_req && frame_word[`CDTT_CMD_WRITE];
    assign ser_idx = frame_word[`CDTT_CMD_IDX_MSB:`CDTT_CMD_IDX_LSB];
    assign ser_data = frame_word[31:0];

    // ----------------------------------------------------------------
    // breakpoint and configuration registers
    // ----------------------------------------------------------------
    logic [31:0] bp [0:`CDTT_NUM_BP-1];
    logic [31:0] cfg;
    logic sup_wr;
    logic [31:0] status_word;
    cdtt_pkg::cdtt_trig_type trig_state;
    logic dbg_active;

    assign sup_wr = sup_wr_in && sup_mode_in;

    genvar gi;
    generate
        for (gi = 0; gi < `CDTT_NUM_BP; gi++)
        begin : g_bp
            always_ff @(posedge clock_in)
            begin
                if (!rst_n_in)
                begin
                    bp[gi] <= `CDTT_BP_RESET;
                end
                else if (ser_wr && ser_idx == 4'(gi))
                begin
                    bp[gi] <= ser_data;
                end
                else if (sup_wr && sup_index_in == 4'(gi))
                begin
                    bp[gi] <= sup_wdata_in;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            cfg <= `CDTT_CFG_RESET;
        end
        else if (ser_wr && ser_idx == `CDTT_IDX_CFG)
        begin
            cfg <= ser_data;
        end
        else if (sup_wr && sup_index_in == `CDTT_IDX_CFG)
        begin
            cfg <= sup_wdata_in;
        end
    end

    assign status_word = {29'h0000_0000, trig_state == cdtt_pkg::CDTT_TRIG_ARMED,
                          halt_request_out, dbg_active};

    function automatic logic [31:0] read_reg(input logic [3:0] idx);
        logic [31:0] val;
        val = 32'h0000_0000;
        if (idx < 4'(`CDTT_NUM_BP))
        begin
            val = bp[idx];
        end
        else if (idx == `CDTT_IDX_CFG)
        begin
            val = cfg;
        end
        else if (idx == `CDTT_IDX_STATUS)
        begin
            val = status_word;
        end
        return val;
    endfunction

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            rd_hold <= 32'h0000_0000;
        end
        else if (ser_req)
        begin
            rd_hold <= read_reg(ser_idx);
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            sup_rdata_out <= 32'h0000_0000;
        end
        else if (sup_rd_in && sup_mode_in)
        begin
            sup_rdata_out <= read_reg(sup_index_in);
        end
    end

    // ----------------------------------------------------------------
    // comparators
    // ----------------------------------------------------------------
    logic addr_hit;
    logic data_hit;
    logic [`CDTT_NUM_PC-1:0] pc_hits;
    logic pc_hit;
    logic [2:0] hits;
    logic [2:0] l1_sel;
    logic [2:0] l2_sel;
    logic l1_cond;
    logic l2_cond;

    assign addr_hit = bus_valid_in &&
        (((bus_addr_in ^ bp[`CDTT_IDX_ADDR]) & ~bp[`CDTT_IDX_ADDR_MASK]) == 32'h0000_0000);
    assign data_hit = bus_valid_in &&
        (((bus_data_in ^ bp[`CDTT_IDX_DATA]) & ~bp[`CDTT_IDX_DATA_MASK]) == 32'h0000_0000);

    generate
        for (gi = 0; gi < `CDTT_NUM_PC; gi++)
        begin : g_pc
            assign pc_hits[gi] = pc_valid_in &&
                (((pc_in ^ bp[`CDTT_IDX_PC0 + gi]) & ~bp[`CDTT_IDX_PC_MASK]) == 32'h0000_0000);
        end
    endgenerate

    assign pc_hit = |pc_hits;
    assign hits = {pc_hit, data_hit, addr_hit};
    assign l1_sel = cfg[`CDTT_CFG_L1_MSB:`CDTT_CFG_L1_LSB];
    assign l2_sel = cfg[`CDTT_CFG_L2_MSB:`CDTT_CFG_L2_LSB];
    // a level fires when every selected term hits; no term selected never fires
    assign l1_cond = (l1_sel != 3'h0) && ((hits & l1_sel) == l1_sel);
    assign l2_cond = (l2_sel != 3'h0) && ((hits & l2_sel) == l2_sel);

    // ----------------------------------------------------------------
    // trigger sequencer and actions
    // ----------------------------------------------------------------
    logic fire;

    // clearing enable while armed must not fire in that same cycle
    assign fire = cfg[`CDTT_CFG_ENABLE] && ((trig_state == cdtt_pkg::CDTT_TRIG_IDLE) ?
        (!cfg[`CDTT_CFG_TWO_LEVEL] && l1_cond) :
        ((trig_state == cdtt_pkg::CDTT_TRIG_ARMED) && l2_cond));

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            trig_state <= cdtt_pkg::CDTT_TRIG_IDLE;
        end
        else if (!cfg[`CDTT_CFG_ENABLE])
        begin
            trig_state <= cdtt_pkg::CDTT_TRIG_IDLE;
        end
        else
        begin
            case (trig_state)
                cdtt_pkg::CDTT_TRIG_IDLE:
                begin
                    if (fire)
                    begin
                        trig_state <= cdtt_pkg::CDTT_TRIG_FIRED;
                    end
                    else if (cfg[`CDTT_CFG_TWO_LEVEL] && l1_cond)
                    begin
                        trig_state <= cdtt_pkg::CDTT_TRIG_ARMED;
                    end
                end
                cdtt_pkg::CDTT_TRIG_ARMED:
                begin
                    if (fire)
                    begin
                        trig_state <= cdtt_pkg::CDTT_TRIG_FIRED;
                    end
                end
                default:
                begin
                    // one shot; rewriting cfg with enable low re-arms
                    trig_state <= cdtt_pkg::CDTT_TRIG_FIRED;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            halt_request_out <= 1'b0;
        end
        else if (fire && !cfg[`CDTT_CFG_ACT_IRQ])
        begin
            halt_request_out <= 1'b1;
        end
        else if (resume_in)
        begin
            halt_request_out <= 1'b0;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            debug_irq_out <= 1'b0;
        end
        else
        begin
            debug_irq_out <= fire && cfg[`CDTT_CFG_ACT_IRQ];
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            dbg_active <= 1'b0;
        end
        else if (fire && cfg[`CDTT_CFG_ACT_IRQ])
        begin
            dbg_active <= 1'b1;
        end
        else if (debug_irq_done_in)
        begin
            dbg_active <= 1'b0;
        end
    end

    // outside debug handling all levels pass; inside only those at or above threshold
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            irq_allow_out <= 1'b1;
        end
        else
        begin
            irq_allow_out <= !dbg_active ||
                (irq_level_in >= cfg[`CDTT_CFG_THR_MSB:`CDTT_CFG_THR_LSB]);
        end
    end

    // ----------------------------------------------------------------
    // trace port
    // ----------------------------------------------------------------
    logic fifo_valid;
    logic fifo_ready;
    logic [31:0] fifo_data;
    logic [31:0] drain_word;
    logic [2:0] nib_cnt;
    cdtt_pkg::cdtt_drain_type drain_state;

    cdtt_fifo #(
        .WIDTH(`CDTT_WORD_BITS),
        .DEPTH(`CDTT_FIFO_DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(trace_valid_in),
        .in_ready_out(trace_ready_out),
        .in_data_in(trace_data_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_ready),
        .out_data_out(fifo_data)
    );

    assign fifo_ready = (drain_state == cdtt_pkg::CDTT_DRAIN_IDLE);

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            drain_state <= cdtt_pkg::CDTT_DRAIN_IDLE;
            drain_word <= 32'h0000_0000;
            nib_cnt <= 3'h0;
        end
        else
        begin
            case (drain_state)
                cdtt_pkg::CDTT_DRAIN_IDLE:
                begin
                    if (fifo_valid)
                    begin
                        drain_word <= fifo_data;
                        nib_cnt <= 3'h0;
                        drain_state <= cdtt_pkg::CDTT_DRAIN_SHIFT;
                    end
                end
                default:
                begin
                    drain_word <= {4'h0, drain_word[31:4]};
                    nib_cnt <= nib_cnt + 3'h1;
                    if (nib_cnt == `CDTT_NIBBLES)
                    begin
                        drain_state <= cdtt_pkg::CDTT_DRAIN_IDLE;
                    end
                end
            endcase
        end
    end

    // low nibble first, one nibble per cpu clock
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            debug_data_bus_out <= 4'h0;
        end
        else if (FULL_TRACE && drain_state == cdtt_pkg::CDTT_DRAIN_SHIFT)
        begin
            debug_data_bus_out <= drain_word[3:0];
        end
        else
        begin
            debug_data_bus_out <= 4'h0;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            processor_status_bus_out <= 4'h0;
            halted_indicator_out <= 1'b0;
        end
        else
        begin
            processor_status_bus_out <= FULL_TRACE ? core_status_in : 4'h0;
            halted_indicator_out <= (core_status_in == `CDTT_PST_HALTED);
        end
    end

    // forwarded cpu clock, so the tool samples status at the core rate
    assign trace_clock_out = clock_in;

endmodule

/* File: tb/cdtt_chk.sv */
`timescale 1ns/1ns
module cdtt_chk
#(
    parameter bit FULL_TRACE = 1'h1
)
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic resume_in,
    input wire logic halt_request_out,
    input wire logic debug_irq_out,
    input wire logic [3:0] core_status_in,
    input wire logic trace_valid_in,
    input wire logic trace_ready_out,
    input wire logic [3:0] processor_status_bus_out,
    input wire logic halted_indicator_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    a_status_copy: assert property (
        FULL_TRACE && $past(rst_n_in) |-> processor_status_bus_out == $past(core_status_in))
        else $error("status bus is not the status of one cycle before");
    a_halted_and: assert property (
        FULL_TRACE |-> halted_indicator_out == &processor_status_bus_out)
        else $error("halted indicator differs from and of status bus");
    a_halted_cause: assert property (
        core_status_in == 4'hF |=> halted_indicator_out)
        else $error("halted indicator low after all-ones status");
    a_halt_hold: assert property (
        halt_request_out && !resume_in |=> halt_request_out)
        else $error("halt request dropped without resume");
    a_halt_release: assert property (
        $fell(halt_request_out) |-> $past(resume_in))
        else $error("halt request fell with no resume");
    a_irq_pulse: assert property (
        debug_irq_out |=> !debug_irq_out)
        else $error("debug interrupt pulse longer than one cycle");
    a_irq_excl: assert property (
        debug_irq_out |-> !$rose(halt_request_out))
        else $error("halt and debug interrupt from one trigger");
    a_ready_fall: assert property (
        $fell(trace_ready_out) |-> $past(trace_valid_in))
        else $error("trace ready fell without a push");
endmodule

bind cdtt_top cdtt_chk #(.FULL_TRACE(FULL_TRACE)) u_chk (.*);

/* File: tb/cdtt_tool.sv */
`timescale 1ns/1ns
module cdtt_tool
(
    output logic debug_serial_clock,
    output logic debug_serial_in,
    input wire logic debug_serial_out
);
    initial
    begin
        debug_serial_clock = 1'h0;
        debug_serial_in = 1'h1;
    end

    // link clock only runs when asked, idle low
    task automatic wake(input int n);
        repeat (n)
        begin
            #80 debug_serial_clock = 1'h1;
            #80 debug_serial_clock = 1'h0;
        end
    endtask

    // msb first out, reply bits shifted in after each edge
    task automatic frame(input logic [39:0] f, output logic [39:0] got);
        got = 40'h0;
        for (int i = 39; i >= 0; i--)
        begin
            debug_serial_in = f[i];
            #80 debug_serial_clock = 1'h1;
            #80 debug_serial_clock = 1'h0;
            got = {got[38:0], debug_serial_out};
        end
        debug_serial_in = ~f[0];
    endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
    logic clock_in = 1'h0, rst_n_in = 1'h0, sup_mode_in = 1'h1, sup_wr_in = 1'h0;
    logic sup_rd_in = 1'h0, bus_valid_in = 1'h0, pc_valid_in = 1'h0, resume_in = 1'h0;
    logic debug_irq_done_in = 1'h0, trace_valid_in = 1'h0;
    logic [3:0] sup_index_in = 4'h0, core_status_in = 4'h0;
    logic [31:0] sup_wdata_in = 32'h0, bus_addr_in = 32'h0, bus_data_in = 32'h0;
    logic [31:0] pc_in = 32'h0, trace_data_in = 32'h0, sup_rdata_out, acc;
    logic [2:0] irq_level_in = 3'h0;
    logic debug_serial_clock, debug_serial_in, debug_serial_out, halt_request_out;
    logic debug_irq_out, irq_allow_out, trace_ready_out, trace_clock_out, halted_indicator_out;
    logic [3:0] processor_status_bus_out, debug_data_bus_out;
    int err_count = 0, n_checks = 0, irq_n = 0, nib_cnt = 0;
    logic [31:0] got_q[$];

    cdtt_tool u_tool
    (
        .debug_serial_clock(debug_serial_clock), .debug_serial_in(debug_serial_in),
        .debug_serial_out(debug_serial_out)
    );
    cdtt_top uut
    (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .debug_serial_clock(debug_serial_clock),
        .debug_serial_in(debug_serial_in), .debug_serial_out(debug_serial_out),
        .sup_mode_in(sup_mode_in), .sup_wr_in(sup_wr_in), .sup_rd_in(sup_rd_in),
        .sup_index_in(sup_index_in), .sup_wdata_in(sup_wdata_in), .sup_rdata_out(sup_rdata_out),
        .bus_valid_in(bus_valid_in), .bus_addr_in(bus_addr_in), .bus_data_in(bus_data_in),
        .pc_valid_in(pc_valid_in), .pc_in(pc_in), .resume_in(resume_in),
        .debug_irq_done_in(debug_irq_done_in), .irq_level_in(irq_level_in),
        .halt_request_out(halt_request_out), .debug_irq_out(debug_irq_out),
        .irq_allow_out(irq_allow_out), .core_status_in(core_status_in),
        .trace_valid_in(trace_valid_in), .trace_data_in(trace_data_in),
        .trace_ready_out(trace_ready_out), .processor_status_bus_out(processor_status_bus_out),
        .debug_data_bus_out(debug_data_bus_out), .trace_clock_out(trace_clock_out),
        .halted_indicator_out(halted_indicator_out)
    );

    always #20 clock_in = ~clock_in;

    // counts irq pulses, reassembles trace words from nibbles
    always @(posedge clock_in)
    begin
        if (debug_irq_out === 1'h1)
            irq_n++;
        if (debug_data_bus_out !== 4'h0 || nib_cnt != 0)
        begin
            acc[nib_cnt*4 +: 4] = debug_data_bus_out;
            nib_cnt++;
            if (nib_cnt == 8)
            begin
                got_q.push_back(acc);
                nib_cnt = 0;
            end
        end
    end

    function automatic logic [31:0] pat(input logic [3:0] i);
        return {4'hC, i, 24'h5A3C0F};
    endfunction

    function automatic logic [31:0] wv(input int k);
        return 32'h8765_4320 | 32'((k % 15) + 1);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic sw(input logic [3:0] idx, input logic [31:0] d);
        @(posedge clock_in);
        sup_wr_in <= 1'h1;
        sup_index_in <= idx;
        sup_wdata_in <= d;
        @(posedge clock_in);
        sup_wr_in <= 1'h0;
    endtask

    task automatic rd_chk(input string what, input logic [3:0] idx, input logic [31:0] exp);
        @(posedge clock_in);
        sup_rd_in <= 1'h1;
        sup_index_in <= idx;
        @(posedge clock_in);
        sup_rd_in <= 1'h0;
        @(posedge clock_in);
        #1;
        chk(what, exp, sup_rdata_out);
    endtask

    // one cycle of bus and pc samples, returns after the answer cycle
    task automatic bus(input logic bv, input logic [31:0] a, d, input logic pv, input logic [31:0] p);
        @(posedge clock_in);
        bus_valid_in <= bv;
        bus_addr_in <= a;
        bus_data_in <= d;
        pc_valid_in <= pv;
        pc_in <= p;
        @(posedge clock_in);
        bus_valid_in <= 1'h0;
        pc_valid_in <= 1'h0;
        @(posedge clock_in);
        #1;
    endtask

    task automatic allow(input logic [2:0] l, input logic e);
        @(posedge clock_in);
        irq_level_in <= l;
        repeat (3) @(posedge clock_in);
        #1;
        chk("irq_allow", {31'h0, e}, {31'h0, irq_allow_out});
    endtask

    task automatic t_regs();
        rd_chk("cfg_reset", 4'h9, 32'h0);
        for (int i = 0; i < 9; i++) sw(4'(i), pat(4'(i)));
        sw(4'hB, 32'hFFFF_FFFF);
        sw(4'hA, 32'hFFFF_FFFF);
        @(posedge clock_in);
        sup_mode_in <= 1'h0;
        sw(4'h0, 32'h0);
        sup_mode_in <= 1'h1;
        for (int i = 0; i < 9; i++) rd_chk("bp_reg", 4'(i), pat(4'(i)));
        rd_chk("unmapped", 4'hB, 32'h0);
        rd_chk("status_ro", 4'hA, 32'h0);
    endtask

    task automatic t_serial();
        logic [39:0] got;
        u_tool.frame({8'h84, 32'h1234_ABCD}, got);
        repeat (6) @(posedge clock_in);
        rd_chk("ser_write", 4'h4, 32'h1234_ABCD);
        u_tool.frame({8'h02, 32'h0}, got);
        u_tool.frame({8'h0F, 32'h0}, got);
        chk("ser_read", pat(4'h2), got[31:0]);
    endtask

    task automatic t_halt();
        sw(4'h0, 32'h0000_1234);
        sw(4'h1, 32'h0000_00FF);
        sw(4'h9, 32'h0000_0801);
        bus(1'h1, 32'h0000_1334, 32'h0, 1'h0, 32'h0);
        chk("halt_miss", 32'h0, {31'h0, halt_request_out});
        bus(1'h1, 32'h0000_12FF, 32'h0, 1'h0, 32'h0);
        chk("halt_hit", 32'h1, {31'h0, halt_request_out});
        @(posedge clock_in);
        resume_in <= 1'h1;
        @(posedge clock_in);
        resume_in <= 1'h0;
        @(posedge clock_in);
        #1;
        chk("halt_resume", 32'h0, {31'h0, halt_request_out});
        sw(4'h9, 32'h0);
    endtask

    task automatic t_irq();
        int n0;
        sw(4'h8, 32'h0);
        sw(4'h7, 32'h0000_8000);
        sw(4'h2, 32'h0000_00C3);
        sw(4'h3, 32'h0);
        sw(4'h9, 32'h0000_0BD4);
        n0 = irq_n;
        bus(1'h1, 32'h0, 32'h0000_00C3, 1'h0, 32'h0);
        bus(1'h0, 32'h0, 32'h0, 1'h1, 32'h0000_8000);
        chk("irq_early", n0, irq_n);
        bus(1'h1, 32'h0, 32'h0000_00C3, 1'h0, 32'h0);
        repeat (2) @(posedge clock_in);
        #1;
        chk("irq_pulse", n0 + 1, irq_n);
        chk("no_halt", 32'h0, {31'h0, halt_request_out});
        allow(3'h2, 1'h0);
        allow(3'h3, 1'h1);
        allow(3'h0, 1'h0);
        @(posedge clock_in);
        debug_irq_done_in <= 1'h1;
        @(posedge clock_in);
        debug_irq_done_in <= 1'h0;
        allow(3'h0, 1'h1);
        sw(4'h9, 32'h0);
    endtask

    task automatic t_trace();
        int n;
        logic full;
        for (int s = 0; s < 16; s++)
        begin
            @(posedge clock_in);
            core_status_in <= 4'(s);
            repeat (2) @(posedge clock_in);
            #1;
            chk("status_bus", 32'(s), {28'h0, processor_status_bus_out});
            chk("halted", {31'h0, s == 15}, {31'h0, halted_indicator_out});
        end
        n = 0;
        full = 1'h0;
        @(posedge clock_in);
        trace_valid_in <= 1'h1;
        trace_data_in <= wv(0);
        for (int t = 0; t < 400 && n < 20; t++)
        begin
            @(posedge clock_in);
            if (trace_ready_out === 1'h1)
                n++;
            else
                full = 1'h1;
            trace_data_in <= wv(n);
        end
        trace_valid_in <= 1'h0;
        repeat (250) @(posedge clock_in);
        chk("fifo_full", 32'h1, {31'h0, full});
        chk("words_out", 32'd20, got_q.size());
        for (int k = 0; k < got_q.size(); k++) chk("trace_word", wv(k), got_q[k]);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #500000;
        err_count++;
        $display("ERROR watchdog expected done seen hang");
        tally_and_finish();
    end

    initial
    begin
        fork
            repeat (8) @(posedge clock_in);
            u_tool.wake(2);
        join_any
        rst_n_in <= 1'h1;
        wait fork;
        u_tool.wake(2);
        t_regs();
        t_serial();
        t_halt();
        t_irq();
        t_trace();
        tally_and_finish();
    end
endmodule
